// ==== include/pmwd_consts.svh ====
// Constants for the power mode and wake detect block.
`ifndef PMWD_CONSTS_SVH
`define PMWD_CONSTS_SVH

// ----------------------------------------------------------------
// Power mode field
// ----------------------------------------------------------------
`define PMWD_MODE_LSB        3
`define PMWD_MODE_MSB        4
`define PMWD_MODE_NORMAL     2'h0
`define PMWD_MODE_ENERGY     2'h1
`define PMWD_MODE_SOFT_PD    2'h3
`define PMWD_MODE_RESET      2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMWD_CLK_PERIOD_NS   20
`define PMWD_WAKE_ENERGY_NS  100
`define PMWD_WAKE_ENERGY_CYC \
    ((`PMWD_WAKE_ENERGY_NS + `PMWD_CLK_PERIOD_NS - 1) / `PMWD_CLK_PERIOD_NS)
`define PMWD_PULSE_PERIOD    16'hFFFF
`define PMWD_PULSE_WIDTH     16'h0004

// ----------------------------------------------------------------
// Wake pattern
// ----------------------------------------------------------------
`define PMWD_SYNC_BYTE       8'hFF
`define PMWD_SYNC_LEN        3'h6
`define PMWD_ADDR_COPIES     5'h10
`define PMWD_NUM_PORTS       5

`endif

// ==== include/pmwd_pkg.sv ====
// Types for the power mode and wake detect block.
package pmwd_pkg;
    typedef enum logic [1:0]
    {
        PMWD_SUB_NORMAL = 2'h0,
        PMWD_SUB_LOW    = 2'h1
    } pmwd_sub_e;

    typedef enum logic [1:0]
    {
        PMWD_WP_SYNC = 2'h0,
        PMWD_WP_ADDR = 2'h1,
        PMWD_WP_DONE = 2'h3
    } pmwd_wp_e;
endpackage

// ==== hdl/pmwd_fifo.sv ====
// Parameterised valid/ready FIFO for the receive byte stream.
`timescale 1ns/1ps
module pmwd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,   // System clock.
    input  wire logic             sys_rst,   // Asynchronous reset, high.
    input  wire logic [WIDTH-1:0] in_data,   // Write data.
    input  wire logic             in_valid,  // Write request.
    output logic                  in_ready,  // Not full.
    output logic      [WIDTH-1:0] out_data,  // Read data.
    output logic                  out_valid, // Not empty.
    input  wire logic             out_ready  // Read accept.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    // ----------------------------------------------------------------
    // Pointers carry an extra wrap bit so full and empty are exact.
    // ----------------------------------------------------------------
    assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];

    // Storage has no reset; only the pointers need one.
    always_ff @(posedge clk_sys)
    begin
        if (in_valid && in_ready)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_valid && out_ready)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ==== hdl/pmwd_power_ctrl.sv ====
// Global power mode controller with energy-sense substates and wake detection.
`timescale 1ns/1ps
`include "pmwd_consts.svh"
module pmwd_power_ctrl
    import pmwd_pkg::*;
(
    input  wire logic        clk_sys,           // System clock, 50 MHz.
    input  wire logic        sys_rst,           // Asynchronous reset, high.
    input  wire logic [7:0]  pd_ctrl_wr_data,   // Control byte; mode in [4:3].
    input  wire logic        pd_ctrl_wr,        // Write strobe for control byte.
    output logic      [1:0]  mode_q,            // Active global mode.
    input  wire logic [15:0] absent_limit,      // Energy absent cycles before low.
    input  wire logic [15:0] wake_energy_limit, // Energy present cycles for wake.
    input  wire logic        energy_in,         // Receive energy sensed.
    input  wire logic        link_up_in,        // Link status.
    input  wire logic [4:0]  port_pd_req,       // Per-port power down request.
    output logic      [4:0]  port_power_on,     // Per-port power enable.
    output logic             pll_enable,        // Internal PLL clock enable.
    output logic             mac_enable,        // MAC enable.
    output logic             host_if_enable,    // Host data interface enable.
    output logic             phy_enable,        // Full PHY enable.
    output logic             phy_rx_sense_on,   // Receive energy sensing enable.
    output logic             mgmt_enable,       // Management interface enable.
    output logic             link_pulse,        // Low substate link pulse.
    output logic             low_substate,      // In energy low substate.
    output logic             soft_reset_pulse,  // One cycle: regs default.
    output logic             strap_sample,      // One cycle: resample straps.
    input  wire logic [47:0] node_addr,         // Our MAC address.
    input  wire logic [7:0]  rx_data,           // Received byte.
    input  wire logic        rx_sof,            // First byte of frame.
    input  wire logic        rx_valid,          // Byte valid.
    output logic             rx_ready,          // Stream ready.
    input  wire logic        rx_for_us,         // Frame addressed to us or broadcast.
    input  wire logic [2:0]  wake_en,           // Enables: pattern, link, energy.
    input  wire logic        pme_route_irq,     // 1 routes events to irq pin.
    input  wire logic [2:0]  wake_clr,          // Clear status bits.
    output logic      [2:0]  wake_status_q,     // Sticky: pattern, link, energy.
    output logic             power_event_out_n, // Power event pin, low active.
    output logic             irq_out_n          // Interrupt pin, low active.
);
    // ----------------------------------------------------------------
    // Global mode register
    // ----------------------------------------------------------------
    logic [1:0] req_mode;
    logic       leave_soft;

    assign req_mode   = pd_ctrl_wr_data[`PMWD_MODE_MSB:`PMWD_MODE_LSB];
    assign leave_soft = pd_ctrl_wr && (mode_q == `PMWD_MODE_SOFT_PD)
                        && (req_mode != `PMWD_MODE_SOFT_PD);

    // A single encoded field makes two modes at once impossible.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q <= `PMWD_MODE_RESET;
        end
        else if (pd_ctrl_wr && (req_mode != 2'h2))
        begin
            mode_q <= req_mode;
        end
    end

    // Leaving soft power down pulses the register reset and strap capture.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            soft_reset_pulse <= 1'b0;
            strap_sample     <= 1'b0;
        end
        else
        begin
            soft_reset_pulse <= leave_soft;
            strap_sample     <= leave_soft;
        end
    end

    // ----------------------------------------------------------------
    // Energy-sense substates
    // ----------------------------------------------------------------
    pmwd_sub_e   sub_q;
    logic [15:0] absent_cnt_q;
    logic [15:0] present_cnt_q;
    logic [15:0] pulse_cnt_q;

    // Absence and presence counters saturate so long idles do not wrap.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            absent_cnt_q  <= 16'h0000;
            present_cnt_q <= 16'h0000;
        end
        else
        begin
            absent_cnt_q  <= energy_in ? 16'h0000 :
                             ((&absent_cnt_q) ? absent_cnt_q : absent_cnt_q + 16'h0001);
            present_cnt_q <= !energy_in ? 16'h0000 :
                             ((&present_cnt_q) ? present_cnt_q : present_cnt_q + 16'h0001);
        end
    end

    // Substate machine, only live in energy mode.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_q <= PMWD_SUB_NORMAL;
        end
        else if (mode_q != `PMWD_MODE_ENERGY)
        begin
            sub_q <= PMWD_SUB_NORMAL;
        end
        else
        begin
            unique case (sub_q)
                PMWD_SUB_NORMAL:
                begin
                    if (absent_cnt_q > absent_limit)
                    begin
                        sub_q <= PMWD_SUB_LOW;
                    end
                end
                PMWD_SUB_LOW:
                begin
                    if (present_cnt_q > 16'(`PMWD_WAKE_ENERGY_CYC))
                    begin
                        sub_q <= PMWD_SUB_NORMAL;
                    end
                end
                default:
                begin
                    sub_q <= PMWD_SUB_NORMAL;
                end
            endcase
        end
    end

    // Sparse link pulses while in the low substate.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pulse_cnt_q <= 16'h0000;
        end
        else if (sub_q != PMWD_SUB_LOW || pulse_cnt_q == `PMWD_PULSE_PERIOD)
        begin
            pulse_cnt_q <= 16'h0000;
        end
        else
        begin
            pulse_cnt_q <= pulse_cnt_q + 16'h0001;
        end
    end

    assign low_substate = (sub_q == PMWD_SUB_LOW);
    assign link_pulse   = low_substate && (pulse_cnt_q < `PMWD_PULSE_WIDTH);

    // ----------------------------------------------------------------
    // Block enables per mode
    // ----------------------------------------------------------------
    logic is_normal;
    assign is_normal       = (mode_q == `PMWD_MODE_NORMAL);
    assign pll_enable      = is_normal;
    assign mac_enable      = is_normal;
    assign host_if_enable  = is_normal;
    assign phy_enable      = is_normal;
    assign phy_rx_sense_on = (mode_q != `PMWD_MODE_SOFT_PD);
    assign mgmt_enable     = 1'b1;
    // Port power down works on top of normal and energy modes; soft power down turns every port off.
    assign port_power_on   = phy_rx_sense_on ? ~port_pd_req : 5'h00;

    // ----------------------------------------------------------------
    // Wake pattern matcher fed through the FIFO
    // ----------------------------------------------------------------
    logic [8:0] fifo_data;
    logic       fifo_valid;
    logic       wp_hit;
    pmwd_wp_e   wp_q;
    logic [2:0] sync_cnt_q;
    logic [2:0] byte_idx_q;
    logic [4:0] copy_cnt_q;
    logic [7:0] exp_byte;

    // Matcher drains every cycle in normal and energy modes; back-pressure reaches rx_ready when full.
    pmwd_fifo #(.WIDTH(9), .DEPTH(16)) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_data   ({rx_sof, rx_data}),
        .in_valid  (rx_valid && rx_for_us && wake_en[0]),
        .in_ready  (rx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (mac_enable || mode_q == `PMWD_MODE_ENERGY)
    );

    // Address bytes go out most significant first, as on the wire.
    function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
        addr_byte = a[8'(47 - 8 * i) -: 8];
    endfunction

    assign exp_byte = addr_byte(node_addr, byte_idx_q);
    logic pop;
    assign pop = fifo_valid && (mac_enable || mode_q == `PMWD_MODE_ENERGY);

    // Search runs over any payload offset; a break falls back to sync.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wp_q       <= PMWD_WP_SYNC;
            sync_cnt_q <= 3'h0;
            byte_idx_q <= 3'h0;
            copy_cnt_q <= 5'h00;
        end
        else if (pop)
        begin
            if (fifo_data[8] || wp_q == PMWD_WP_DONE)
            begin
                // New frame: no partial match survives.
                wp_q       <= PMWD_WP_SYNC;
                byte_idx_q <= 3'h0;
                copy_cnt_q <= 5'h00;
                sync_cnt_q <= (fifo_data[7:0] == `PMWD_SYNC_BYTE) ? 3'h1 : 3'h0;
            end
            else
            begin
                unique case (wp_q)
                    PMWD_WP_SYNC:
                    begin
                        if (fifo_data[7:0] != `PMWD_SYNC_BYTE)
                        begin
                            sync_cnt_q <= 3'h0;
                        end
                        else if (sync_cnt_q == `PMWD_SYNC_LEN - 3'h1)
                        begin
                            wp_q <= PMWD_WP_ADDR;
                        end
                        else
                        begin
                            sync_cnt_q <= sync_cnt_q + 3'h1;
                        end
                    end
                    PMWD_WP_ADDR:
                    begin
                        if (fifo_data[7:0] != exp_byte)
                        begin
                            // An extra 0xFF right after a full sync run only lengthens it,
                            // so the address search stays armed; other breaks resync.
                            wp_q       <= (fifo_data[7:0] == `PMWD_SYNC_BYTE
                                           && byte_idx_q == 3'h0 && copy_cnt_q == 5'h00)
                                          ? PMWD_WP_ADDR : PMWD_WP_SYNC;
                            byte_idx_q <= 3'h0;
                            copy_cnt_q <= 5'h00;
                            sync_cnt_q <= (fifo_data[7:0] == `PMWD_SYNC_BYTE) ? 3'h1 : 3'h0;
                        end
                        else if (byte_idx_q == 3'h5)
                        begin
                            byte_idx_q <= 3'h0;
                            copy_cnt_q <= copy_cnt_q + 5'h01;
                            if (copy_cnt_q == `PMWD_ADDR_COPIES - 5'h01)
                            begin
                                wp_q <= PMWD_WP_DONE;
                            end
                        end
                        else
                        begin
                            byte_idx_q <= byte_idx_q + 3'h1;
                        end
                    end
                    default:
                    begin
                        wp_q <= PMWD_WP_SYNC;
                    end
                endcase
            end
        end
    end

    assign wp_hit = pop && !fifo_data[8] && wp_q == PMWD_WP_ADDR && byte_idx_q == 3'h5
                    && fifo_data[7:0] == exp_byte && copy_cnt_q == `PMWD_ADDR_COPIES - 5'h01;

    // ----------------------------------------------------------------
    // Wake events and status
    // ----------------------------------------------------------------
    logic       link_q;
    logic [2:0] ev;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_q <= 1'b0;
        end
        else
        begin
            link_q <= link_up_in;
        end
    end

    assign ev[0] = wp_hit;
    assign ev[1] = link_up_in && !link_q;
    assign ev[2] = energy_in && (present_cnt_q == wake_energy_limit);

    // Set beats clear in the same cycle; each source gated by its enable.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wake_status_q <= 3'h0;
        end
        else
        begin
            wake_status_q <= (wake_status_q & ~wake_clr) | (ev & wake_en);
        end
    end

    // Pins driven from flops so they never glitch.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_event_out_n <= 1'b1;
            irq_out_n         <= 1'b1;
        end
        else
        begin
            power_event_out_n <= !((|wake_status_q) && !pme_route_irq);
            irq_out_n         <= !((|wake_status_q) && pme_route_irq);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_mode_reset;
        @(posedge clk_sys) $fell(sys_rst) |-> mode_q == `PMWD_MODE_NORMAL;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not normal after reset");

    property p_mode_write;
        @(posedge clk_sys) disable iff (sys_rst)
        pd_ctrl_wr && req_mode == `PMWD_MODE_ENERGY |=> mode_q == `PMWD_MODE_ENERGY;
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("energy mode not entered");

    property p_energy_off;
        @(posedge clk_sys) disable iff (sys_rst)
        mode_q == `PMWD_MODE_ENERGY |-> !pll_enable && !mac_enable && phy_rx_sense_on;
    endproperty
    a_energy_off: assert property (p_energy_off) else $error("energy mode enables wrong");

    property p_soft_off;
        @(posedge clk_sys) disable iff (sys_rst)
        mode_q == `PMWD_MODE_SOFT_PD |-> !phy_rx_sense_on && mgmt_enable && !pll_enable;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("soft power down enables wrong");

    property p_leave_soft;
        @(posedge clk_sys) disable iff (sys_rst)
        leave_soft |=> soft_reset_pulse && strap_sample ##1 !soft_reset_pulse;
    endproperty
    a_leave_soft: assert property (p_leave_soft) else $error("soft exit pulse wrong");

    property p_low_exit;
        @(posedge clk_sys) disable iff (sys_rst)
        low_substate && mode_q == `PMWD_MODE_ENERGY && energy_in [*7] |=> !low_substate;
    endproperty
    a_low_exit: assert property (p_low_exit) else $error("low substate not left");

    property p_link_wake;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(link_up_in) && wake_en[1] |=> wake_status_q[1];
    endproperty
    a_link_wake: assert property (p_link_wake) else $error("link wake not raised");

    property p_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        wake_status_q[0] && !wake_clr[0] |=> wake_status_q[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("wake status lost");

    property p_pin;
        @(posedge clk_sys) disable iff (sys_rst)
        (|wake_status_q) && !pme_route_irq |=> !power_event_out_n;
    endproperty
    a_pin: assert property (p_pin) else $error("power event pin not asserted");
endmodule

// ==== dv/pmwd_link_partner.sv ====
// Link partner model that feeds receive byte frames into the stream port.
`timescale 1ns/1ps
module pmwd_link_partner (
    input  wire logic        clk_sys,          // System clock.
    input  wire logic        rx_ready,         // Stream ready.
    input  wire logic [47:0] node_addr,        // Address to repeat.
    output logic      [7:0]  rx_data = 8'h00,  // Byte.
    output logic             rx_sof = 1'b0,    // First byte of frame.
    output logic             rx_valid = 1'b0,  // Byte valid.
    output logic             rx_for_us = 1'b0  // Frame addressed here.
);
    // ------------------------------------------------------------
    // Byte transfers
    // ------------------------------------------------------------
    // Holds the byte until an edge with ready high takes it.
    task automatic put(input logic [7:0] b, input logic sof);
        rx_data  = b;
        rx_sof   = sof;
        rx_valid = 1'b1;
        while (!rx_ready)
            @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
    endtask

    // Junk, sync run, then address copies; copy number bad is zeroed.
    task automatic frame(input int pre, input int ns, input int cp, input int bad,
                         input logic us);
        rx_for_us = us;
        for (int k = 0; k < pre + ns + cp * 6; k++)
            put(k < pre ? 8'h3C : k < pre + ns ? 8'hFF : (k - pre - ns) / 6 == bad ? 8'h00
                : node_addr[47 - 8 * ((k - pre - ns) % 6) -: 8], k == 0);
        // Released data shows the inverse, so a stale byte can never pass.
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    // Offers bytes without pause and counts how many the stream takes.
    task automatic fill(output int n);
        rx_for_us = 1'b1;
        put(8'h5A, 1'b1);
        n = 1 + rx_ready;
        repeat (38) @(posedge clk_sys) #1 n += rx_ready;
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask
endmodule

// ==== dv/test_pmwd_power_ctrl.sv ====
// Self-checking bench for the power mode and wake detect block.
`timescale 1ns/1ps
module test_pmwd_power_ctrl;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, pd_ctrl_wr = 1'b0, energy_in = 1'b0;
    logic        link_up_in = 1'b0, pme_route_irq = 1'b0;
    logic [7:0]  pd_ctrl_wr_data = 8'h00, rx_data;
    logic [4:0]  port_pd_req = 5'h00, port_power_on;
    logic [2:0]  wake_en = 3'h0, wake_clr = 3'h0, wake_status_q;
    logic [15:0] absent_limit = 16'h0008, wake_energy_limit = 16'h0004;
    logic [47:0] node_addr = 48'h02A4C3E91B57;
    logic [1:0]  mode_q;
    logic        rx_sof, rx_valid, rx_ready, rx_for_us, pll_enable, mac_enable;
    logic        host_if_enable, phy_enable, phy_rx_sense_on, mgmt_enable, link_pulse;
    logic        low_substate, soft_reset_pulse, strap_sample, power_event_out_n, irq_out_n;
    int          err_total = 0, checks = 0, n_acc;
    wire  [5:0]  en6 = {pll_enable, mac_enable, host_if_enable, phy_enable,
                        phy_rx_sense_on, mgmt_enable};
    // Mode table: write code, expected mode, expected enables.
    localparam logic [11:0] MODE_TAB [4] = '{12'h503, 12'h903, 12'h03F, 12'hF01};
    // Frame table: junk, sync length, copies, broken copy, addressed, hit.
    int          pre_t [6] = '{9, 0, 0, 0, 0, 3};
    int          ns_t  [6] = '{6, 6, 6, 0, 6, 7};
    int          cp_t  [6] = '{16, 16, 8, 8, 16, 16};
    int          bad_t [6] = '{99, 7, 99, 99, 99, 99};
    localparam logic [5:0] US_T = 6'h2F, HIT_T = 6'h21;

    pmwd_power_ctrl u_dut (.clk_sys, .sys_rst, .pd_ctrl_wr_data, .pd_ctrl_wr, .mode_q,
        .absent_limit, .wake_energy_limit, .energy_in, .link_up_in, .port_pd_req,
        .port_power_on, .pll_enable, .mac_enable, .host_if_enable, .phy_enable,
        .phy_rx_sense_on, .mgmt_enable, .link_pulse, .low_substate, .soft_reset_pulse,
        .strap_sample, .node_addr, .rx_data, .rx_sof, .rx_valid, .rx_ready, .rx_for_us,
        .wake_en, .pme_route_irq, .wake_clr, .wake_status_q, .power_event_out_n, .irq_out_n);
    pmwd_link_partner u_lp (.clk_sys, .rx_ready, .node_addr, .rx_data, .rx_sof, .rx_valid,
        .rx_for_us);

    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Helpers; inputs change 1 ns after the edge to avoid races.
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys) #1;
    endtask

    task automatic wr_mode(input logic [1:0] m);
        pd_ctrl_wr_data = {3'h0, m, 3'h0};
        pd_ctrl_wr      = 1'b1;
        cyc(1);
        pd_ctrl_wr      = 1'b0;
    endtask

    task automatic clr(input logic [2:0] b);
        wake_clr = b;
        cyc(1);
        wake_clr = 3'h0;
        cyc(2);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // The whole run needs about 740 cycles; the watchdog allows far more.
    initial
    begin
        #400000;
        err_total++;
        wrap_up;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        chk(mode_q, 8'h00);
        chk(en6, 8'h3F);
        chk({power_event_out_n, irq_out_n, rx_ready}, 8'h07);
        port_pd_req = 5'h0A;
        cyc(1);
        chk(port_power_on, 8'h15);
        for (int i = 0; i < 4; i++)
        begin
            wr_mode(MODE_TAB[i][11:10]);
            chk(mode_q, MODE_TAB[i][9:8]);
            chk(en6, MODE_TAB[i][5:0]);
            cyc(1);
        end
        chk(port_power_on, 8'h00);
        wake_en = 3'h1;
        u_lp.fill(n_acc);
        chk(n_acc, 8'h10);
        wr_mode(2'h0);
        chk({soft_reset_pulse, strap_sample}, 8'h03);
        cyc(1);
        chk({soft_reset_pulse, strap_sample}, 8'h00);
        cyc(40);
        chk(rx_ready, 8'h01);
        clr(3'h7);
        // Energy substates; the absent limit is eight cycles.
        wr_mode(2'h1);
        cyc(2);
        chk({low_substate, link_pulse}, 8'h03);
        cyc(10);
        chk({low_substate, link_pulse}, 8'h02);
        energy_in = 1'b1;
        cyc(3);
        chk(low_substate, 8'h01);
        cyc(5);
        chk(low_substate, 8'h00);
        energy_in = 1'b0;
        wr_mode(2'h0);
        // A short burst of energy must not wake; a long one must.
        wake_en = 3'h4;
        energy_in = 1'b1;
        cyc(2);
        energy_in = 1'b0;
        cyc(4);
        chk(wake_status_q, 8'h00);
        energy_in = 1'b1;
        cyc(8);
        chk({wake_status_q, power_event_out_n}, 8'h08);
        energy_in = 1'b0;
        clr(3'h4);
        chk({wake_status_q, power_event_out_n}, 8'h01);
        // Link-up while disabled, then enabled and routed to the interrupt pin.
        wake_en = 3'h0;
        link_up_in = 1'b1;
        cyc(3);
        chk(wake_status_q, 8'h00);
        link_up_in = 1'b0;
        wake_en = 3'h2;
        pme_route_irq = 1'b1;
        cyc(2);
        link_up_in = 1'b1;
        cyc(3);
        chk({wake_status_q, power_event_out_n, irq_out_n}, 8'h0A);
        clr(3'h2);
        pme_route_irq = 1'b0;
        wake_en = 3'h1;
        for (int i = 0; i < 6; i++)
        begin
            u_lp.frame(pre_t[i], ns_t[i], cp_t[i], bad_t[i], US_T[i]);
            cyc(6);
            chk({wake_status_q[0], power_event_out_n}, {HIT_T[i], !HIT_T[i]});
            clr(3'h7);
        end
        wrap_up;
    end
endmodule
